/* File: cfs_defines.svh */
`ifndef CFS_DEFINES_SVH
`define CFS_DEFINES_SVH

`define CFS_CMD_OT_FAULT      8'h4f
`define CFS_CMD_OT_WARN       8'h51
`define CFS_CMD_TON_MAX       8'h62
`define CFS_CMD_TEMP_STATUS   8'h7d
`define CFS_CMD_TEMP_READ     8'h8d
`define CFS_CMD_PCT_LIMITS    8'hd7

`define CFS_RST_OT_FAULT      16'h0091
`define CFS_RST_OT_WARN       16'h007d
`define CFS_RST_TON_MAX       16'h000a
`define CFS_RST_PCT_LIMITS    8'h00
`define CFS_RST_WORD          16'h0000

`define CFS_OC_RUN_LEN        2'h3
`define CFS_OC_OFF_DELAY      2'h3
`define CFS_HICCUP_RISES      3'h7
`define CFS_OT_HYST           16'h0014

`define CFS_TSTAT_OTF         7
`define CFS_TSTAT_OTW         6

`define CFS_FLG_OC            0
`define CFS_FLG_OV            1
`define CFS_FLG_UV            2
`define CFS_FLG_OT            3
`define CFS_FLG_OTW           4
`define CFS_FLG_BG            5
`define CFS_FLG_TONMAX        6
`define CFS_FLG_OVW           7
`define CFS_FAULT_BITS        8'h6f

`define CFS_CLK_NS            50
`define CFS_MS_NS             1000000
`define CFS_MS_CYCLES         (`CFS_MS_NS / `CFS_CLK_NS)

`endif

/* File: cfs_link_if.sv */
`timescale 1ns/10ps
interface cfs_link_if;
   logic [15:0] ot_fault_thr;
   logic [15:0] ot_warn_thr;
   logic [15:0] ton_max;
   logic [7:0]  pct_limits;
   logic [7:0]  temp_status;
   logic        temp_valid;
   logic [15:0] temp_sample;
   logic        oc_event;
   logic        cycle_end;
   logic        run_clear;
   logic        delay_arm;
   logic        oc_fault;
   logic        delay_done;

   modport sup (input ot_fault_thr, ot_warn_thr, ton_max, oc_fault, delay_done,
                output temp_status, temp_valid, temp_sample, oc_event, cycle_end,
                run_clear, delay_arm);
   modport regs (input temp_status, temp_valid, temp_sample,
                 output ot_fault_thr, ot_warn_thr, ton_max, pct_limits);
   modport occ (input oc_event, cycle_end, run_clear, delay_arm,
                output oc_fault, delay_done);
endinterface

/* File: cfs_oc_count.sv */
`timescale 1ns/10ps
`include "cfs_defines.svh"
module cfs_oc_count (
   input  wire logic clk,
   input  wire logic reset_n,
   cfs_link_if.occ   lk
);
   typedef struct packed {
      logic [1:0] cnt;
      logic       seen;
      logic       fault;
      logic [1:0] dly;
      logic       armed;
      logic       done;
   } cfs_occ_t;

   cfs_occ_t q, d;
   logic     ev;

   always_comb begin
      d = q;
      d.fault = 1'b0;
      d.done = 1'b0;
      ev = q.seen | lk.oc_event;
      if (lk.run_clear) begin
         d.cnt = 2'h0;
         d.seen = 1'b0;
      end else if (lk.cycle_end) begin
         d.seen = 1'b0;
         if (!ev) begin
            d.cnt = 2'h0;
         end else if (q.cnt == `CFS_OC_RUN_LEN - 2'h1) begin
            d.cnt = 2'h0;
            d.fault = 1'b1;
         end else begin
            d.cnt = q.cnt + 2'h1;
         end
      end else begin
         d.seen = ev;
      end
      if (!lk.delay_arm) begin
         d.armed = 1'b0;
         d.dly = 2'h0;
      end else if (!q.armed) begin
         d.armed = 1'b1;
      end else if (lk.cycle_end) begin
         if (q.dly == `CFS_OC_OFF_DELAY - 2'h1) begin
            d.done = 1'b1;
         end else begin
            d.dly = q.dly + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lk.oc_fault   = q.fault;
   assign lk.delay_done = q.done;
endmodule // cfs_oc_count

/* File: cfs_pkg.sv */
package cfs_pkg;

   typedef enum logic [1:0] {
      CFS_RESP_IGNORE,
      CFS_RESP_LATCH,
      CFS_RESP_RESTART,
      CFS_RESP_RESERVED
   } cfs_resp_t;

   typedef enum logic [2:0] {
      ST_OFF, ST_START, ST_RUN, ST_OC_DELAY, ST_HICCUP, ST_LATCHED, ST_COOL
   } cfs_state_t;

   typedef struct packed {
      logic ls_oc;
      logic hs_peak;
      logic neg_oc;
      logic ov;
      logic uv;
      logic overvoltage_warning;
      logic uvw;
      logic fixed_hi;
      logic fixed_lo;
      logic voltage_select_pin;
      logic bg_ot;
      logic prebias_hi;
      logic enable;
      logic clear_faults;
   } cfs_pins_t;

endpackage

/* File: cfs_regs.sv */
`timescale 1ns/10ps
`include "cfs_defines.svh"
module cfs_regs (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   input  wire logic [15:0] cmd_wdata,
   output logic      [15:0] cmd_rdata,
   output logic             cmd_rvalid,
   cfs_link_if.regs         lk
);
   typedef struct packed {
      logic [15:0] ot_fault;
      logic [15:0] ot_warn;
      logic [15:0] ton_max;
      logic [7:0]  pct;
      logic [15:0] temp;
      logic [15:0] rdata;
      logic        rvalid;
   } cfs_regs_t;

   cfs_regs_t q, d;

   always_comb begin
      d = q;
      d.rvalid = 1'b0;
      if (lk.temp_valid) begin
         d.temp = lk.temp_sample;
      end
      if (cmd_wr) begin
         case (cmd_code)
            `CFS_CMD_OT_FAULT:   d.ot_fault = cmd_wdata;
            `CFS_CMD_OT_WARN:    d.ot_warn = cmd_wdata;
            `CFS_CMD_TON_MAX:    d.ton_max = cmd_wdata;
            `CFS_CMD_PCT_LIMITS: d.pct = cmd_wdata[7:0];
            default: ;
         endcase
      end
      if (cmd_rd) begin
         d.rvalid = 1'b1;
         case (cmd_code)
            `CFS_CMD_OT_FAULT:    d.rdata = q.ot_fault;
            `CFS_CMD_OT_WARN:     d.rdata = q.ot_warn;
            `CFS_CMD_TON_MAX:     d.rdata = q.ton_max;
            `CFS_CMD_TEMP_STATUS: d.rdata = {8'h00, lk.temp_status};
            `CFS_CMD_TEMP_READ:   d.rdata = q.temp;
            `CFS_CMD_PCT_LIMITS:  d.rdata = {8'h00, q.pct};
            default:              d.rdata = `CFS_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '{`CFS_RST_OT_FAULT, `CFS_RST_OT_WARN, `CFS_RST_TON_MAX, `CFS_RST_PCT_LIMITS,
                `CFS_RST_WORD, `CFS_RST_WORD, 1'b0};
      end else begin
         q <= d;
      end
   end

   assign lk.ot_fault_thr = q.ot_fault;
   assign lk.ot_warn_thr  = q.ot_warn;
   assign lk.ton_max      = q.ton_max;
   assign lk.pct_limits   = q.pct;
   assign cmd_rdata       = q.rdata;
   assign cmd_rvalid      = q.rvalid;
endmodule // cfs_regs

/* File: cfs_stage_model.sv */
`timescale 1ns/10ps
module cfs_stage_model (
   input  wire logic clk,
   output logic      cycle_end,
   output logic      pwm_hs,
   output logic      pwm_ls,
   output logic      ls_min_off,
   output logic      rise_tick
);
   logic [3:0] phase;
   initial begin
      phase = 4'h0;
      {cycle_end, pwm_hs, pwm_ls, ls_min_off, rise_tick} = 5'h00;
   end
   // Eight clocks per switching cycle and two cycles per rise time keep the run short.
   // The minimum off-time sits one clock ahead of the cycle end, never on it.
   always @(negedge clk) begin
      phase <= phase + 4'h1;
      pwm_hs <= (phase[2:0] < 3'h3);
      pwm_ls <= (phase[2:0] >= 3'h3);
      ls_min_off <= (phase[2:0] == 3'h5);
      cycle_end <= (phase[2:0] == 3'h6);
      rise_tick <= (phase == 4'he);
   end
endmodule // cfs_stage_model

/* File: cfs_supervisor.sv */
`timescale 1ns/10ps
`include "cfs_defines.svh"
module cfs_supervisor #(
   parameter int unsigned MS_CYCLES = `CFS_MS_CYCLES
) (
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic [7:0]  CMD_CODE,
   input  wire logic        CMD_WR,
   input  wire logic        CMD_RD,
   input  wire logic [15:0] CMD_WDATA,
   input  wire logic        CYCLE_END,
   input  wire logic        PWM_HS,
   input  wire logic        PWM_LS,
   input  wire logic        LS_MIN_OFF,
   input  wire logic        SS_DONE,
   input  wire logic        SS_RISE_TICK,
   input  wire logic        TEMP_VALID,
   input  wire logic [15:0] TEMP_SAMPLE,
   input  wire logic [1:0]  OC_RESP,
   input  wire logic [1:0]  OV_RESP,
   input  wire logic [1:0]  UV_RESP,
   input  wire logic [1:0]  OT_RESP,
   input  wire logic        NEGATIVE_LIMIT_DISABLE,
   input  wire logic [7:0]  ALERT_MASK,
   input  wire logic        LS_OC_DET,
   input  wire logic        HIGH_SIDE_PEAK_LIMIT,
   input  wire logic        NEG_OC_DET,
   input  wire logic        OV_DET,
   input  wire logic        UV_DET,
   input  wire logic        OVW_DET,
   input  wire logic        UVW_DET,
   input  wire logic        FIXED_OV_HI_DET,
   input  wire logic        FIXED_OV_LO_DET,
   input  wire logic        VOLTAGE_SELECT_PIN,
   input  wire logic        BG_OT_DET,
   input  wire logic        PREBIAS_HI_DET,
   input  wire logic        CONTROL_ENABLE_PIN,
   input  wire logic        CLEAR_FAULTS,
   output logic      [15:0] CMD_RDATA,
   output logic             CMD_RVALID,
   output logic      [7:0]  OV_UV_PERCENT_LIMITS,
   output logic      [7:0]  FAULT_STATUS,
   output logic             HS_GATE,
   output logic             LS_GATE,
   output logic             CONVERT_EN,
   output logic             POWER_GOOD_OUTPUT_O,
   output logic             POWER_GOOD_OUTPUT_OE,
   output logic             ALERT_O,
   output logic             ALERT_OE
);
   typedef struct packed {
      cfs_pkg::cfs_pins_t  s1;
      cfs_pkg::cfs_pins_t  s2;
      cfs_pkg::cfs_state_t st;
      logic                cool_bg;
      logic                clr_d;
      logic [14:0]         ms_div;
      logic [15:0]         ms_cnt;
      logic                ton_expired;
      logic [2:0]          rise_cnt;
      logic                hs_cut;
      logic                neg_seen;
      logic                neg_skip;
      logic                ot_hot;
      logic                ot_warm;
      logic                ot_cool;
      logic [7:0]          flags;
      logic                hs_gate;
      logic                ls_gate;
      logic                conv_en;
      logic                pg_oe;
      logic                alert_oe;
   } cfs_sup_t;

   cfs_sup_t           q, d;
   cfs_pkg::cfs_pins_t pins_in;
   cfs_pkg::cfs_resp_t oc_resp, ov_resp, uv_resp, ot_resp;
   logic               clr, ov_now, ov_act, switching, uv_fault, clamp_on, neg_now;
   logic               pg_release;
   logic [7:0]         ev;

   cfs_link_if lk ();

   cfs_regs u_regs (
      .clk       (CLK),
      .reset_n   (RESET_N),
      .cmd_code  (CMD_CODE),
      .cmd_wr    (CMD_WR),
      .cmd_rd    (CMD_RD),
      .cmd_wdata (CMD_WDATA),
      .cmd_rdata (CMD_RDATA),
      .cmd_rvalid(CMD_RVALID),
      .lk        (lk.regs)
   );

   cfs_oc_count u_oc (
      .clk    (CLK),
      .reset_n(RESET_N),
      .lk     (lk.occ)
   );

   // True once the die has cooled by the hysteresis below the fault threshold.
   function automatic logic cool_enough(input logic [15:0] t, input logic [15:0] thr);
      return ({1'b0, t} + {1'b0, `CFS_OT_HYST}) <= {1'b0, thr};
   endfunction

   function automatic cfs_pkg::cfs_state_t after_off(input cfs_pkg::cfs_resp_t r);
      return (r == cfs_pkg::CFS_RESP_RESTART) ? cfs_pkg::ST_HICCUP : cfs_pkg::ST_LATCHED;
   endfunction

   assign pins_in = '{LS_OC_DET, HIGH_SIDE_PEAK_LIMIT, NEG_OC_DET, OV_DET, UV_DET, OVW_DET,
                      UVW_DET, FIXED_OV_HI_DET, FIXED_OV_LO_DET, VOLTAGE_SELECT_PIN,
                      BG_OT_DET, PREBIAS_HI_DET, CONTROL_ENABLE_PIN, CLEAR_FAULTS};
   assign oc_resp = cfs_pkg::cfs_resp_t'(OC_RESP);
   assign ov_resp = cfs_pkg::cfs_resp_t'(OV_RESP);
   assign uv_resp = cfs_pkg::cfs_resp_t'(UV_RESP);
   assign ot_resp = cfs_pkg::cfs_resp_t'(OT_RESP);

   assign lk.temp_valid  = TEMP_VALID;
   assign lk.temp_sample = TEMP_SAMPLE;
   assign lk.oc_event    = q.s2.ls_oc | q.s2.hs_peak;
   assign lk.cycle_end   = CYCLE_END;
   assign lk.run_clear   = ~(q.st inside {cfs_pkg::ST_START, cfs_pkg::ST_RUN,
                                          cfs_pkg::ST_OC_DELAY});
   assign lk.delay_arm   = (q.st == cfs_pkg::ST_OC_DELAY);
   assign lk.temp_status = {q.flags[`CFS_FLG_OT], q.flags[`CFS_FLG_OTW], 6'h00};

   always_comb begin
      d = q;
      d.s1 = pins_in;
      d.s2 = q.s1;
      d.clr_d = q.s2.clear_faults;
      clr = q.s2.clear_faults & ~q.clr_d;

      // Comparator paths see two sync stages and the output register, so each comparator reaction lags by three clocks; overcurrent also waits for the run counter.
      ov_now = q.s2.ov | (q.s2.voltage_select_pin ? q.s2.fixed_hi : q.s2.fixed_lo);
      ov_act = ov_now & (ov_resp != cfs_pkg::CFS_RESP_IGNORE);
      switching = q.st inside {cfs_pkg::ST_START, cfs_pkg::ST_RUN, cfs_pkg::ST_OC_DELAY};
      uv_fault = q.s2.uv & switching & ((q.st != cfs_pkg::ST_START) | q.ton_expired);

      if (TEMP_VALID) begin
         d.ot_hot = TEMP_SAMPLE >= lk.ot_fault_thr;
         d.ot_warm = TEMP_SAMPLE >= lk.ot_warn_thr;
         d.ot_cool = cool_enough(TEMP_SAMPLE, lk.ot_fault_thr);
      end

      ev = 8'h00;
      ev[`CFS_FLG_OC] = lk.oc_fault;
      ev[`CFS_FLG_OV] = ov_now;
      ev[`CFS_FLG_UV] = uv_fault;
      ev[`CFS_FLG_OT] = q.ot_hot;
      ev[`CFS_FLG_OTW] = q.ot_warm;
      ev[`CFS_FLG_BG] = q.s2.bg_ot;
      ev[`CFS_FLG_TONMAX] = uv_fault & (q.st == cfs_pkg::ST_START);
      ev[`CFS_FLG_OVW] = q.s2.overvoltage_warning | q.s2.prebias_hi;
      // A new event in the clearing cycle survives the clear.
      d.flags = ev | (q.flags & ~{8{clr}});
      d.alert_oe = |(d.flags & ~ALERT_MASK);

      if (q.st == cfs_pkg::ST_START) begin
         if (q.ms_div == 15'(MS_CYCLES - 1)) begin
            d.ms_div = 15'h0000;
            d.ms_cnt = q.ms_cnt + 16'h0001;
         end else begin
            d.ms_div = q.ms_div + 15'h0001;
         end
         d.ton_expired = q.ton_expired | (q.ms_cnt >= lk.ton_max);
      end else begin
         d.ms_div = 15'h0000;
         d.ms_cnt = 16'h0000;
         d.ton_expired = 1'b0;
      end

      if (q.st == cfs_pkg::ST_HICCUP) begin
         if (SS_RISE_TICK) begin
            d.rise_cnt = q.rise_cnt + 3'h1;
         end
      end else begin
         d.rise_cnt = 3'h0;
      end

      unique case (q.st)
         cfs_pkg::ST_OFF: begin
            if (q.s2.enable) begin
               d.st = cfs_pkg::ST_START;
            end
         end
         cfs_pkg::ST_START, cfs_pkg::ST_RUN: begin
            if (q.st == cfs_pkg::ST_START && SS_DONE) begin
               d.st = cfs_pkg::ST_RUN;
            end
            if (lk.oc_fault && oc_resp != cfs_pkg::CFS_RESP_IGNORE) begin
               d.st = cfs_pkg::ST_OC_DELAY;
            end
         end
         cfs_pkg::ST_OC_DELAY: begin
            if (lk.delay_done) begin
               d.st = after_off(oc_resp);
            end
         end
         cfs_pkg::ST_HICCUP: begin
            if (SS_RISE_TICK && q.rise_cnt == `CFS_HICCUP_RISES - 3'h1) begin
               d.st = cfs_pkg::ST_START;
            end
         end
         cfs_pkg::ST_LATCHED: begin
            d.st = cfs_pkg::ST_LATCHED;
         end
         cfs_pkg::ST_COOL: begin
            if (q.cool_bg ? !q.s2.bg_ot : q.ot_cool) begin
               d.st = cfs_pkg::ST_START;
            end
         end
         default: d.st = cfs_pkg::ST_OFF;
      endcase

      // Later checks win: disable over all, then bandgap, overvoltage, undervoltage, temperature.
      if (switching) begin
         if (q.ot_hot && ot_resp == cfs_pkg::CFS_RESP_LATCH) begin
            d.st = cfs_pkg::ST_LATCHED;
         end else if (q.ot_hot && ot_resp == cfs_pkg::CFS_RESP_RESTART) begin
            d.st = cfs_pkg::ST_COOL;
            d.cool_bg = 1'b0;
         end
         if (uv_fault && uv_resp != cfs_pkg::CFS_RESP_IGNORE) begin
            d.st = after_off(uv_resp);
         end
         if (ov_act) begin
            d.st = after_off(ov_resp);
         end
      end
      if (q.s2.bg_ot && q.st != cfs_pkg::ST_OFF) begin
         d.st = cfs_pkg::ST_COOL;
         d.cool_bg = 1'b1;
      end
      if (!q.s2.enable) begin
         d.st = cfs_pkg::ST_OFF;
      end

      d.conv_en = d.st inside {cfs_pkg::ST_START, cfs_pkg::ST_RUN, cfs_pkg::ST_OC_DELAY};

      if (CYCLE_END) begin
         d.hs_cut = 1'b0;
      end else begin
         d.hs_cut = q.hs_cut | (q.s2.hs_peak & PWM_HS);
      end
      d.hs_gate = d.conv_en & PWM_HS & ~d.hs_cut & ~ov_act;

      clamp_on = ~NEGATIVE_LIMIT_DISABLE & ~ov_act;
      neg_now = q.s2.neg_oc & clamp_on;
      if (CYCLE_END) begin
         d.neg_seen = 1'b0;
         d.neg_skip = (q.neg_seen | neg_now) & clamp_on;
      end else begin
         d.neg_seen = q.neg_seen | neg_now;
         d.neg_skip = q.neg_skip & clamp_on;
      end
      // The minimum off-time window stays on even under the clamp so that
      // the negative comparator gets a fresh look every period.
      d.ls_gate = ov_act |
                  (d.conv_en & (LS_MIN_OFF |
                   (PWM_LS & ~PWM_HS & ~neg_now & ~q.neg_skip)));

      pg_release = (q.st == cfs_pkg::ST_RUN) & ~|(q.flags & `CFS_FAULT_BITS) &
                   ~q.s2.uvw & ~q.s2.overvoltage_warning & ~q.s2.prebias_hi & ~ov_now;
      d.pg_oe = ~pg_release;
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         q <= '{s1: '0, s2: '0, st: cfs_pkg::ST_OFF, pg_oe: 1'b1, default: '0};
      end else begin
         q <= d;
      end
   end

   assign FAULT_STATUS         = q.flags;
   assign OV_UV_PERCENT_LIMITS = lk.pct_limits;
   assign HS_GATE              = q.hs_gate;
   assign LS_GATE              = q.ls_gate;
   assign CONVERT_EN           = q.conv_en;
   assign POWER_GOOD_OUTPUT_O  = 1'b0;
   assign POWER_GOOD_OUTPUT_OE = q.pg_oe;
   assign ALERT_O              = 1'b0;
   assign ALERT_OE             = q.alert_oe;
endmodule // cfs_supervisor

/* File: cfs_supervisor_props.sv */
`timescale 1ns/10ps
module cfs_supervisor_props #(
   parameter int unsigned MS_CYCLES = 20000
) (
   input wire logic       CLK,
   input wire logic       RESET_N,
   input wire logic       CMD_RD,
   input wire logic       LS_MIN_OFF,
   input wire logic [1:0] OV_RESP,
   input wire logic       NEGATIVE_LIMIT_DISABLE,
   input wire logic [7:0] ALERT_MASK,
   input wire logic       HIGH_SIDE_PEAK_LIMIT,
   input wire logic       NEG_OC_DET,
   input wire logic       OV_DET,
   input wire logic       BG_OT_DET,
   input wire logic       CMD_RVALID,
   input wire logic [7:0] FAULT_STATUS,
   input wire logic       HS_GATE,
   input wire logic       LS_GATE,
   input wire logic       CONVERT_EN,
   input wire logic       POWER_GOOD_OUTPUT_OE,
   input wire logic       ALERT_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // Four samples cover the two-stage pin synchroniser and the registered gate.
   sequence neg_seen;
      (NEG_OC_DET && !NEGATIVE_LIMIT_DISABLE && !OV_DET)[*4];
   endsequence
   sequence ov_seen;
      (OV_DET && OV_RESP != 2'h0)[*4];
   endsequence
   sequence unmasked_fault;
      ((FAULT_STATUS & ~ALERT_MASK) != 8'h00)[*2];
   endsequence
   a_read_answer: assert property (CMD_RD |=> CMD_RVALID)
      else $error("read strobe not answered");
   a_answer_cause: assert property (CMD_RVALID |-> $past(CMD_RD))
      else $error("read answer without strobe");
   a_alert_raised: assert property (unmasked_fault |-> ALERT_OE)
      else $error("unmasked fault without alert");
   a_alert_quiet: assert property (((FAULT_STATUS & ~ALERT_MASK) == 8'h00)[*2] |-> !ALERT_OE)
      else $error("alert without unmasked fault");
   a_pg_fault_low: assert property (((FAULT_STATUS & 8'h6f) != 8'h00)[*2] |-> POWER_GOOD_OUTPUT_OE)
      else $error("power good released during fault");
   a_pg_off_low: assert property ((!CONVERT_EN)[*2] |-> POWER_GOOD_OUTPUT_OE)
      else $error("power good released while stopped");
   a_peak_cut: assert property (HIGH_SIDE_PEAK_LIMIT[*4] |-> !HS_GATE)
      else $error("high side on during peak limit");
   a_neg_clamp: assert property (neg_seen ##0 !$past(LS_MIN_OFF) |-> !LS_GATE)
      else $error("low side on during negative current");
   a_min_off: assert property ($past(LS_MIN_OFF) && CONVERT_EN |-> LS_GATE)
      else $error("low side off in minimum off time");
   a_ov_hs_off: assert property (ov_seen |-> !HS_GATE)
      else $error("high side on during overvoltage");
   a_bg_stop: assert property (BG_OT_DET[*4] |-> !CONVERT_EN && FAULT_STATUS[5])
      else $error("bandgap overheat not handled");
endmodule // cfs_supervisor_props

/* File: cfs_supervisor_test.sv */
`timescale 1ns/10ps
`include "cfs_defines.svh"
module cfs_supervisor_test;
   logic        CLK, RESET_N, CMD_WR, CMD_RD, CYCLE_END, PWM_HS, PWM_LS, LS_MIN_OFF;
   logic        SS_DONE, SS_RISE_TICK, TEMP_VALID, NEGATIVE_LIMIT_DISABLE, LS_OC_DET;
   logic        HIGH_SIDE_PEAK_LIMIT, NEG_OC_DET, OV_DET, UV_DET, OVW_DET, UVW_DET;
   logic        FIXED_OV_HI_DET, FIXED_OV_LO_DET, VOLTAGE_SELECT_PIN, BG_OT_DET;
   logic        PREBIAS_HI_DET, CONTROL_ENABLE_PIN, CLEAR_FAULTS, CMD_RVALID, HS_GATE;
   logic        LS_GATE, CONVERT_EN, POWER_GOOD_OUTPUT_O, POWER_GOOD_OUTPUT_OE;
   logic        ALERT_O, ALERT_OE;
   logic [7:0]  CMD_CODE, ALERT_MASK, OV_UV_PERCENT_LIMITS, FAULT_STATUS;
   logic [15:0] CMD_WDATA, TEMP_SAMPLE, CMD_RDATA;
   logic [1:0]  OC_RESP, OV_RESP, UV_RESP, OT_RESP;
   int          errors, n_compared;
   logic [7:0]  codes [4] = '{8'h4f, 8'h51, 8'h62, 8'hd7};
   logic [15:0] rst_v [4] = '{`CFS_RST_OT_FAULT, `CFS_RST_OT_WARN, `CFS_RST_TON_MAX, 16'h0000};
   logic [15:0] new_v [4] = '{16'h0090, 16'h0070, 16'h0002, 16'h00a5};

   cfs_supervisor #(.MS_CYCLES(20)) i_dut (
      .CLK, .RESET_N, .CMD_CODE, .CMD_WR, .CMD_RD, .CMD_WDATA, .CYCLE_END, .PWM_HS, .PWM_LS,
      .LS_MIN_OFF, .SS_DONE, .SS_RISE_TICK, .TEMP_VALID, .TEMP_SAMPLE, .OC_RESP, .OV_RESP,
      .UV_RESP, .OT_RESP, .NEGATIVE_LIMIT_DISABLE, .ALERT_MASK, .LS_OC_DET,
      .HIGH_SIDE_PEAK_LIMIT, .NEG_OC_DET, .OV_DET, .UV_DET, .OVW_DET, .UVW_DET,
      .FIXED_OV_HI_DET, .FIXED_OV_LO_DET, .VOLTAGE_SELECT_PIN, .BG_OT_DET, .PREBIAS_HI_DET,
      .CONTROL_ENABLE_PIN, .CLEAR_FAULTS, .CMD_RDATA, .CMD_RVALID, .OV_UV_PERCENT_LIMITS,
      .FAULT_STATUS, .HS_GATE, .LS_GATE, .CONVERT_EN, .POWER_GOOD_OUTPUT_O,
      .POWER_GOOD_OUTPUT_OE, .ALERT_O, .ALERT_OE);

   cfs_stage_model i_stage (.clk(CLK), .cycle_end(CYCLE_END), .pwm_hs(PWM_HS),
      .pwm_ls(PWM_LS), .ls_min_off(LS_MIN_OFF), .rise_tick(SS_RISE_TICK));

   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   task automatic test_done;
      if (errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] code, input logic [15:0] d);
      CMD_CODE = code;
      CMD_WDATA = d;
      CMD_WR = 1'b1;
      @(negedge CLK);
      CMD_WR = 1'b0;
      @(negedge CLK);
   endtask

   task automatic rd(input logic [7:0] code, input logic [15:0] exp);
      CMD_CODE = code;
      CMD_RD = 1'b1;
      @(negedge CLK);
      CMD_RD = 1'b0;
      check("rvalid", 16'(CMD_RVALID), 16'h1);
      check("rdata", CMD_RDATA, exp);
      @(negedge CLK);
   endtask

   task automatic clocks(input int n);
      repeat (n) @(negedge CLK);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge CLK iff CYCLE_END);
      clocks(2);
   endtask

   task automatic clr;
      CLEAR_FAULTS = 1'b1;
      clocks(4);
      CLEAR_FAULTS = 1'b0;
      clocks(2);
   endtask

   task automatic stop;
      CONTROL_ENABLE_PIN = 1'b0;
      clr();
      check("flags", 16'(FAULT_STATUS), 16'h0);
   endtask

   task automatic go;
      CONTROL_ENABLE_PIN = 1'b1;
      clocks(4);
      check("start", 16'(CONVERT_EN), 16'h1);
      SS_DONE = 1'b1;
      @(negedge CLK);
      SS_DONE = 1'b0;
      clocks(3);
   endtask

   // The pulse sits mid-cycle so the synchronised copy never spills over a cycle end.
   task automatic oc_run(input logic [7:0] hits, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge CLK iff CYCLE_END);
         clocks(2);
         LS_OC_DET = hits[i];
         clocks(2);
         LS_OC_DET = 1'b0;
      end
      cycles(1);
   endtask

   initial begin
      {RESET_N, CMD_WR, CMD_RD, SS_DONE, TEMP_VALID, NEGATIVE_LIMIT_DISABLE, LS_OC_DET} = '0;
      {HIGH_SIDE_PEAK_LIMIT, NEG_OC_DET, OV_DET, UV_DET, OVW_DET, UVW_DET} = '0;
      {FIXED_OV_HI_DET, FIXED_OV_LO_DET, VOLTAGE_SELECT_PIN, BG_OT_DET} = '0;
      {PREBIAS_HI_DET, CONTROL_ENABLE_PIN, CLEAR_FAULTS, ALERT_MASK} = '0;
      {CMD_CODE, CMD_WDATA, TEMP_SAMPLE, OC_RESP, OV_RESP, UV_RESP, OT_RESP} = '0;
      clocks(2);
      RESET_N = 1'b1;
      check("pg_reset", 16'({ALERT_O, POWER_GOOD_OUTPUT_O, POWER_GOOD_OUTPUT_OE}), 16'h1);
      for (int i = 0; i < 4; i++) begin
         rd(codes[i], rst_v[i]);
         wr(codes[i], new_v[i]);
         rd(codes[i], new_v[i]);
      end
      check("pct", 16'(OV_UV_PERCENT_LIMITS), 16'h00a5);
      wr(8'h7d, 16'hffff);
      wr(8'h8d, 16'hffff);
      rd(8'h8d, 16'h0000);
      rd(8'h00, 16'h0000);
      ALERT_MASK = 8'h10;
      TEMP_SAMPLE = 16'h0080;
      TEMP_VALID = 1'b1;
      @(negedge CLK);
      TEMP_VALID = 1'b0;
      clocks(3);
      rd(8'h8d, 16'h0080);
      rd(8'h7d, 16'h0040);
      check("alert_mask", 16'(ALERT_OE), 16'h0);
      ALERT_MASK = 8'h00;
      TEMP_SAMPLE = 16'h0095;
      TEMP_VALID = 1'b1;
      @(negedge CLK);
      TEMP_VALID = 1'b0;
      clocks(3);
      rd(8'h7d, 16'h00c0);
      check("alert", 16'(ALERT_OE), 16'h1);
      check("ot_ign", 16'(FAULT_STATUS), 16'h0018);
      TEMP_SAMPLE = 16'h0010;
      TEMP_VALID = 1'b1;
      @(negedge CLK);
      TEMP_VALID = 1'b0;
      stop();
      UV_DET = 1'b1;
      CONTROL_ENABLE_PIN = 1'b1;
      clocks(30);
      check("ton_early", 16'(FAULT_STATUS[6]), 16'h0);
      clocks(20);
      check("ton_late", 16'(FAULT_STATUS[6]), 16'h1);
      UV_DET = 1'b0;
      go();
      clr();
      check("pg_run", 16'(POWER_GOOD_OUTPUT_OE), 16'h0);
      UV_DET = 1'b1;
      clocks(5);
      check("uv_ign", {FAULT_STATUS, 7'h0, CONVERT_EN}, 16'h0401);
      UV_DET = 1'b0;
      FIXED_OV_HI_DET = 1'b1;
      clocks(5);
      check("fix_lo", 16'(FAULT_STATUS[1]), 16'h0);
      VOLTAGE_SELECT_PIN = 1'b1;
      PREBIAS_HI_DET = 1'b1;
      clocks(5);
      check("fix_hi", {FAULT_STATUS, 7'h0, CONVERT_EN}, 16'h8601);
      check("pg_pre", 16'(POWER_GOOD_OUTPUT_OE), 16'h1);
      {FIXED_OV_HI_DET, VOLTAGE_SELECT_PIN, PREBIAS_HI_DET} = '0;
      clr();
      OC_RESP = 2'h1;
      oc_run(8'h36, 6);
      check("oc_gap", 16'(FAULT_STATUS[0]), 16'h0);
      oc_run(8'h07, 3);
      check("oc_flag", {FAULT_STATUS, 7'h0, ALERT_OE}, 16'h0101);
      cycles(2);
      clocks(1);
      check("oc_hold", 16'({HS_GATE, CONVERT_EN}), 16'h3);
      cycles(1);
      check("oc_latch", {HS_GATE, LS_GATE, CONVERT_EN}, 16'h0);
      stop();
      go();
      OC_RESP = 2'h2;
      oc_run(8'h07, 3);
      cycles(3);
      repeat (6) @(posedge CLK iff SS_RISE_TICK);
      clocks(2);
      check("hic_wait", 16'(CONVERT_EN), 16'h0);
      @(posedge CLK iff SS_RISE_TICK);
      clocks(2);
      check("hic_back", 16'(CONVERT_EN), 16'h1);
      stop();
      go();
      BG_OT_DET = 1'b1;
      clocks(5);
      check("bg_off", {FAULT_STATUS, 7'h0, CONVERT_EN}, 16'h2000);
      BG_OT_DET = 1'b0;
      clocks(5);
      check("bg_back", 16'(CONVERT_EN), 16'h1);
      stop();
      go();
      OV_RESP = 2'h1;
      OV_DET = 1'b1;
      NEG_OC_DET = 1'b1;
      clocks(5);
      check("ov_gates", 16'({FAULT_STATUS[1], HS_GATE, LS_GATE}), 16'h5);
      {OV_DET, NEG_OC_DET} = '0;
      stop();
      go();
      OC_RESP = 2'h0;
      HIGH_SIDE_PEAK_LIMIT = 1'b1;
      NEG_OC_DET = 1'b1;
      cycles(4);
      clocks(1);
      check("oc_ign", 16'({FAULT_STATUS[0], HS_GATE, CONVERT_EN}), 16'h5);
      NEGATIVE_LIMIT_DISABLE = 1'b1;
      clocks(4);
      check("neg_dis", 16'(LS_GATE), 16'h1);
      {HIGH_SIDE_PEAK_LIMIT, NEG_OC_DET} = '0;
      test_done();
   end

   initial begin
      repeat (20000) @(posedge CLK);
      errors++;
      test_done();
   end
endmodule // cfs_supervisor_test

bind cfs_supervisor cfs_supervisor_props #(.MS_CYCLES(MS_CYCLES)) i_props (
   .CLK(CLK), .RESET_N(RESET_N), .CMD_RD(CMD_RD), .LS_MIN_OFF(LS_MIN_OFF),
   .OV_RESP(OV_RESP), .NEGATIVE_LIMIT_DISABLE(NEGATIVE_LIMIT_DISABLE),
   .ALERT_MASK(ALERT_MASK), .HIGH_SIDE_PEAK_LIMIT(HIGH_SIDE_PEAK_LIMIT),
   .NEG_OC_DET(NEG_OC_DET), .OV_DET(OV_DET), .BG_OT_DET(BG_OT_DET),
   .CMD_RVALID(CMD_RVALID), .FAULT_STATUS(FAULT_STATUS), .HS_GATE(HS_GATE),
   .LS_GATE(LS_GATE), .CONVERT_EN(CONVERT_EN),
   .POWER_GOOD_OUTPUT_OE(POWER_GOOD_OUTPUT_OE), .ALERT_OE(ALERT_OE));
